/* shared/fla_map.svh */
// Constants for the absolute-to-register field load: opcode layout, widths and field limits.
`ifndef FLA_LOAD_MAP_SVH
`define FLA_LOAD_MAP_SVH

`define FLA_WORD_W 16
`define FLA_DATA_W 32
`define FLA_OPC_HI_MSB 15
`define FLA_OPC_HI_LSB 10
`define FLA_OPC_HI_VAL 6'h01
`define FLA_OPC_LO_MSB 8
`define FLA_OPC_LO_LSB 5
`define FLA_OPC_LO_VAL 4'hd
`define FLA_SET_BIT 9
`define FLA_FILE_BIT 4
`define FLA_DEST_MSB 3
`define FLA_DEST_LSB 0
`define FLA_WIDTH_CODE_W 5
`define FLA_OFFSET_W 5
`define FLA_FULL_WIDTH 6'h20
`define FLA_WIDTH_FULL_CODE 5'h00
`define FLA_SPAN_W 7
`define FLA_SPAN_LIMIT 7'h20
`define FLA_WORD_STEP 27'h0000001
`define FLA_ALIGN_ZERO 5'h00

`endif

/* shared/fla_pkg.sv */
// Types shared by the field load decoder and its extension unit.
package fla_pkg;

	typedef enum logic
	{
		FLA_ZERO_EXT = 1'b0,
		FLA_SIGN_EXT = 1'b1
	} fla_ext_t;

	typedef enum logic [5:0]
	{
		FLA_IDLE = 6'b000001,
		FLA_ADDR_LO = 6'b000010,
		FLA_ADDR_HI = 6'b000100,
		FLA_READ_FIRST = 6'b001000,
		FLA_READ_SECOND = 6'b010000,
		FLA_EXTEND = 6'b100000
	} fla_state_t;

endpackage

/* rtl/fla_field_extend.sv */
// Right-justifies a bit field taken from two memory words and extends it to 32 bits.
`timescale 1ns/10ps
`default_nettype none
`include "fla_map.svh"

module fla_field_extend
(
	// Source words, lower address first.
	input wire logic [31:0] loWord,
	input wire logic [31:0] hiWord,
	// Field placement and extension.
	input wire logic [4:0] bitOffset,
	input wire logic [5:0] widthFull,
	input wire fla_pkg::fla_ext_t extendMode,
	// Extended result.
	output logic [31:0] result
);
	import fla_pkg::*;

	logic [63:0] joined;
	logic [63:0] shifted;
	logic [4:0] topIdx;
	logic fillBit;

	always_comb
	begin
		joined = {hiWord, loWord};
		shifted = joined >> bitOffset;
		topIdx = 5'(widthFull - 6'h01);
		fillBit = (extendMode == FLA_SIGN_EXT) ? shifted[topIdx] : 1'b0;
		for (int i = 0; i < `FLA_DATA_W; i++)
		begin
			result[i] = (6'(i) < widthFull) ? shifted[i] : fillBit;
		end
	end

endmodule
`default_nettype wire

/* rtl/fla_load_exec.sv */
// Decoder and sequencer for the load of an absolute-addressed bit field into a general register.
`timescale 1ns/10ps
`default_nettype none
`include "fla_map.svh"

module fla_load_exec
(
	// Clock, reset and enable.
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic clkEn,
	// Instruction word stream.
	input wire logic wordValid,
	input wire logic [15:0] wordData,
	output logic wordReady,
	output logic opcodeReject,
	output logic busy,
	// Field parameters programmed by set_field_parameters.
	input wire logic [4:0] field_width_set_zero,
	input wire fla_pkg::fla_ext_t extend_mode_set_zero,
	input wire logic [4:0] field_width_set_one,
	input wire fla_pkg::fla_ext_t extend_mode_set_one,
	// Local memory read port.
	output logic memRdReq,
	output logic [31:0] memRdAddr,
	input wire logic memRdValid,
	input wire logic [31:0] memRdData,
	// Register file write port.
	output logic regWrEn,
	output logic regWrFile,
	output logic [3:0] regWrIdx,
	output logic [31:0] regWrData,
	// Status flag update.
	output logic statusWrEn,
	output logic flagN,
	output logic flagZ,
	output logic flagV
);
	import fla_pkg::*;

	fla_state_t state_q, state_d;
	logic setSel_q, setSel_d;
	logic file_q, file_d;
	logic [3:0] dest_q, dest_d;
	logic [31:0] addr_q, addr_d;
	logic [31:0] word0_q, word0_d;
	logic [31:0] word1_q, word1_d;
	logic [5:0] width_q, width_d;
	fla_ext_t ext_q, ext_d;
	logic wrEn_q, wrEn_d;
	logic [31:0] wrData_q, wrData_d;
	logic flagN_q, flagN_d;
	logic flagZ_q, flagZ_d;
	logic reject_q, reject_d;

	logic opcodeMatch;
	logic [4:0] widthCode;
	logic [6:0] span;
	logic needSecond;
	logic [31:0] extended;

	// The extension unit always sees both words; a field that ends inside the first word never looks at the second.
	fla_field_extend u_extend
	(
		.loWord(word0_q),
		.hiWord(word1_q),
		.bitOffset(addr_q[4:0]),
		.widthFull(width_q),
		.extendMode(ext_q),
		.result(extended)
	);

	always_comb
	begin
		opcodeMatch = (wordData[`FLA_OPC_HI_MSB:`FLA_OPC_HI_LSB] == `FLA_OPC_HI_VAL) &&
			(wordData[`FLA_OPC_LO_MSB:`FLA_OPC_LO_LSB] == `FLA_OPC_LO_VAL);
		widthCode = setSel_q ? field_width_set_one : field_width_set_zero;
		span = 7'(addr_q[4:0]) + 7'(width_q);
		needSecond = span > `FLA_SPAN_LIMIT;
		wordReady = (state_q == FLA_IDLE) || (state_q == FLA_ADDR_LO) || (state_q == FLA_ADDR_HI);
		memRdReq = (state_q == FLA_READ_FIRST) || (state_q == FLA_READ_SECOND);
		memRdAddr = {addr_q[31:5], `FLA_ALIGN_ZERO};
		if (state_q == FLA_READ_SECOND)
		begin
			memRdAddr = {27'(addr_q[31:5] + `FLA_WORD_STEP), `FLA_ALIGN_ZERO};
		end
		busy = (state_q != FLA_IDLE);
	end

	always_comb
	begin
		state_d = state_q;
		setSel_d = setSel_q;
		file_d = file_q;
		dest_d = dest_q;
		addr_d = addr_q;
		word0_d = word0_q;
		word1_d = word1_q;
		width_d = width_q;
		ext_d = ext_q;
		wrEn_d = 1'b0;
		wrData_d = wrData_q;
		flagN_d = flagN_q;
		flagZ_d = flagZ_q;
		reject_d = 1'b0;
		case (state_q)
			FLA_IDLE:
			begin
				if (wordValid && opcodeMatch)
				begin
					setSel_d = wordData[`FLA_SET_BIT];
					file_d = wordData[`FLA_FILE_BIT];
					dest_d = wordData[`FLA_DEST_MSB:`FLA_DEST_LSB];
					state_d = FLA_ADDR_LO;
				end
				else if (wordValid)
				begin
					reject_d = 1'b1;
				end
			end
			FLA_ADDR_LO:
			begin
				if (wordValid)
				begin
					addr_d[15:0] = wordData;
					state_d = FLA_ADDR_HI;
				end
			end
			FLA_ADDR_HI:
			begin
				if (wordValid)
				begin
					addr_d[31:16] = wordData;
					// A width code of zero stands for a full 32-bit field.
					width_d = (widthCode == `FLA_WIDTH_FULL_CODE) ? `FLA_FULL_WIDTH : 6'(widthCode);
					ext_d = setSel_q ? extend_mode_set_one : extend_mode_set_zero;
					state_d = FLA_READ_FIRST;
				end
			end
			FLA_READ_FIRST:
			begin
				if (memRdValid)
				begin
					word0_d = memRdData;
					word1_d = '0;
					state_d = needSecond ? FLA_READ_SECOND : FLA_EXTEND;
				end
			end
			FLA_READ_SECOND:
			begin
				if (memRdValid)
				begin
					word1_d = memRdData;
					state_d = FLA_EXTEND;
				end
			end
			FLA_EXTEND:
			begin
				wrData_d = extended;
				flagN_d = extended[31];
				flagZ_d = (extended == '0);
				wrEn_d = 1'b1;
				state_d = FLA_IDLE;
			end
			default:
			begin
				state_d = FLA_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			state_q <= FLA_IDLE;
			setSel_q <= 1'b0;
			file_q <= 1'b0;
			dest_q <= '0;
			addr_q <= '0;
			word0_q <= '0;
			word1_q <= '0;
			width_q <= `FLA_FULL_WIDTH;
			ext_q <= FLA_ZERO_EXT;
			wrEn_q <= 1'b0;
			wrData_q <= '0;
			flagN_q <= 1'b0;
			flagZ_q <= 1'b0;
			reject_q <= 1'b0;
		end
		else if (clkEn)
		begin
			state_q <= state_d;
			setSel_q <= setSel_d;
			file_q <= file_d;
			dest_q <= dest_d;
			addr_q <= addr_d;
			word0_q <= word0_d;
			word1_q <= word1_d;
			width_q <= width_d;
			ext_q <= ext_d;
			wrEn_q <= wrEn_d;
			wrData_q <= wrData_d;
			flagN_q <= flagN_d;
			flagZ_q <= flagZ_d;
			reject_q <= reject_d;
		end
	end

	// Carry has no output at all, so the core keeps its old value; overflow always reads cleared.
	assign regWrEn = wrEn_q;
	assign regWrFile = file_q;
	assign regWrIdx = dest_q;
	assign regWrData = wrData_q;
	assign statusWrEn = wrEn_q;
	assign flagN = flagN_q;
	assign flagZ = flagZ_q;
	assign flagV = 1'b0;
	assign opcodeReject = reject_q;

	default clocking fla_cb @(posedge clk_sys iff clkEn);
	endclocking
	default disable iff (reset);

	a_opcode_accept: assert property ((state_q == FLA_IDLE) && wordValid && opcodeMatch |=> state_q == FLA_ADDR_LO)
		else $error("Matching opcode was not accepted.");
	a_foreign_reject: assert property ((state_q == FLA_IDLE) && wordValid && !opcodeMatch |=> opcodeReject && state_q == FLA_IDLE)
		else $error("Foreign opcode was not rejected.");
	a_three_words: assert property ((state_q == FLA_ADDR_HI) && wordValid |=> state_q == FLA_READ_FIRST && addr_q[31:16] == $past(wordData))
		else $error("High address half not taken as third word.");
	a_read_aligned: assert property (memRdReq |-> memRdAddr[4:0] == `FLA_ALIGN_ZERO)
		else $error("Memory read address is not word aligned.");
	a_second_read: assert property ((state_q == FLA_READ_FIRST) && memRdValid && needSecond |=> state_q == FLA_READ_SECOND)
		else $error("Field crossing a word did not fetch the second word.");
	a_set_select: assert property ((state_q == FLA_IDLE) && wordValid && opcodeMatch |=> setSel_q == $past(wordData[`FLA_SET_BIT]))
		else $error("Set select not captured from the opcode.");
	a_zero_fill: assert property (regWrEn && ext_q == FLA_ZERO_EXT && width_q != `FLA_FULL_WIDTH |-> (regWrData >> width_q) == '0)
		else $error("Zero extension left upper bits set.");
	a_flag_clear: assert property (regWrEn |-> statusWrEn && !flagV)
		else $error("Overflow not cleared with the register write.");
	a_flag_neg: assert property (regWrEn |-> flagN == regWrData[31])
		else $error("Negative flag disagrees with the result.");
	a_flag_zero: assert property (regWrEn |-> flagZ == (regWrData == '0))
		else $error("Zero flag disagrees with the result.");
	a_single_write: assert property (regWrEn |=> !regWrEn)
		else $error("Register write lasted more than one cycle.");
	a_file_route: assert property ((state_q == FLA_IDLE) && wordValid && opcodeMatch |=> regWrFile == $past(wordData[`FLA_FILE_BIT]))
		else $error("Register file select not taken from the opcode.");

	c_single_read: cover property ((state_q == FLA_READ_FIRST) && memRdValid && !needSecond);
	c_double_read: cover property ((state_q == FLA_READ_SECOND) && memRdValid);
	c_negative_load: cover property (regWrEn && flagN);
	c_foreign_word: cover property (opcodeReject);

endmodule
`default_nettype wire

/* tb/fla_mem_model.sv */
// Local memory model that answers aligned word reads after a chosen wait.
`timescale 1ns/10ps
`default_nettype none
module fla_mem_model
(
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic reset,
	// Read port.
	input wire logic memRdReq,
	input wire logic [31:0] memRdAddr,
	output logic memRdValid,
	output logic [31:0] memRdData,
	// Wait cycles before each answer.
	input wire logic [3:0] waitCycles
);
	logic [3:0] waitQ;
	logic [31:0] lastQ;
	// Content is a function of the address, so the bench can predict each word.
	function automatic logic [31:0] wordAt(input logic [31:0] a);
		wordAt = {a[15:0], ~a[15:0]} ^ 32'ha5c3_0f96;
	endfunction
	assign memRdValid = memRdReq && (waitQ == waitCycles);
	// Between answers the data shows the inverse of the last word, so stale data never matches.
	assign memRdData = memRdValid ? wordAt(memRdAddr) : ~lastQ;
	always_ff @(posedge clk_sys)
	begin
		waitQ <= (reset || !memRdReq || memRdValid) ? 4'h0 : waitQ + 4'h1;
		lastQ <= reset ? 32'h0000_0000 : (memRdValid ? memRdData : lastQ);
	end
endmodule
`default_nettype wire

/* tb/tb_field_load_absolute_exec.sv */
// Self-checking bench for the absolute-address field load.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin badCount++; $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_field_load_absolute_exec;
	import fla_pkg::*;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic wordValid = 1'b0;
	logic [15:0] wordData = 16'h0000;
	logic [4:0] widthZero = 5'h00, widthOne = 5'h00;
	fla_ext_t modeZero = FLA_ZERO_EXT, modeOne = FLA_ZERO_EXT;
	logic [3:0] waitCycles = 4'h0;
	logic wordReady, opcodeReject, busy, memRdReq, memRdValid;
	logic regWrEn, regWrFile, statusWrEn, flagN, flagZ, flagV;
	logic [31:0] memRdAddr, memRdData, regWrData;
	logic [3:0] regWrIdx;
	int badCount = 0, nTests = 0;
	int stallCycles = 0;
	logic clkEn = 1'b1;
	always #50 clk_sys = ~clk_sys;
	fla_load_exec i_dut (.clk_sys(clk_sys), .reset(reset), .clkEn(clkEn), .wordValid(wordValid),
		.wordData(wordData), .wordReady(wordReady), .opcodeReject(opcodeReject), .busy(busy),
		.field_width_set_zero(widthZero), .extend_mode_set_zero(modeZero),
		.field_width_set_one(widthOne), .extend_mode_set_one(modeOne), .memRdReq(memRdReq),
		.memRdAddr(memRdAddr), .memRdValid(memRdValid), .memRdData(memRdData), .regWrEn(regWrEn),
		.regWrFile(regWrFile), .regWrIdx(regWrIdx), .regWrData(regWrData), .statusWrEn(statusWrEn),
		.flagN(flagN), .flagZ(flagZ), .flagV(flagV));
	fla_mem_model i_mem (.clk_sys(clk_sys), .reset(reset), .memRdReq(memRdReq), .memRdAddr(memRdAddr),
		.memRdValid(memRdValid), .memRdData(memRdData), .waitCycles(waitCycles));
	function automatic logic [31:0] memWord(input logic [31:0] a);
		memWord = {a[15:0], ~a[15:0]} ^ 32'ha5c3_0f96;
	endfunction
	task automatic reportAndStop();
		if (badCount == 0 && nTests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic sendWord(input logic [15:0] w);
		wordData = w;
		`CHK(wordReady, 1'b1)
		@(posedge clk_sys);
		#10;
	endtask
	task automatic loadAndCheck(input logic sel, input logic file, input logic [3:0] idx, input logic [31:0] addr);
		logic [63:0] pair;
		logic [31:0] expData;
		logic [4:0] code;
		logic [5:0] width;
		int n;
		int reads;
		pair = {memWord({addr[31:5] + 27'h1, 5'h00}), memWord({addr[31:5], 5'h00})} >> addr[4:0];
		code = sel ? widthOne : widthZero;
		width = (code == 5'h00) ? 6'h20 : {1'b0, code};
		expData = pair[31:0];
		for (n = 31; n >= int'(width); n--)
			expData[n] = ((sel ? modeOne : modeZero) == FLA_SIGN_EXT) ? pair[width - 6'h1] : 1'b0;
		wordValid = 1'b1;
		sendWord({6'h01, sel, 4'hd, file, idx});
		sendWord(addr[15:0]);
		sendWord(addr[31:16]);
		wordValid = 1'b0;
		// Parameters move after the last word; the load in flight must not see it.
		widthZero = ~widthZero;
		widthOne = ~widthOne;
		`CHK(busy, 1'b1)
		`CHK({memRdReq, wordReady}, 2'b10)
		`CHK(memRdAddr, {addr[31:5], 5'h00})
		// A frozen core must hold its pending read and raise no write.
		if (stallCycles > 0)
		begin
			clkEn = 1'b0;
			for (n = 0; n < stallCycles; n++)
			begin
				@(posedge clk_sys);
				#10;
				`CHK({busy, memRdReq, regWrEn}, 3'b110)
			end
			clkEn = 1'b1;
		end
		n = 0;
		reads = 0;
		while (regWrEn !== 1'b1 && n < 40)
		begin
			if (memRdReq === 1'b1 && memRdValid === 1'b1)
				reads++;
			@(posedge clk_sys);
			#10;
			n++;
		end
		if (n == 40)
		begin
			badCount++;
			reportAndStop();
		end
		`CHK(regWrData, expData)
		`CHK(reads, (int'(addr[4:0]) + int'(width) > 32) ? 2 : 1)
		`CHK({regWrFile, regWrIdx}, {file, idx})
		`CHK(statusWrEn, 1'b1)
		`CHK(flagN, expData[31])
		`CHK(flagZ, expData == 32'h0000_0000)
		`CHK(flagV, 1'b0)
		@(posedge clk_sys);
		#10;
		`CHK(regWrEn, 1'b0)
	endtask
	task automatic testZeroExtend();
		widthZero = 5'h05;
		modeZero = FLA_ZERO_EXT;
		widthOne = 5'h0c;
		modeOne = FLA_SIGN_EXT;
		waitCycles = 4'h0;
		stallCycles = 3;
		loadAndCheck(1'b0, 1'b0, 4'h3, 32'h0001_5503);
		stallCycles = 0;
	endtask
	task automatic testSignWide();
		widthZero = 5'h01;
		widthOne = 5'h00;
		modeOne = FLA_SIGN_EXT;
		waitCycles = 4'h3;
		loadAndCheck(1'b1, 1'b1, 4'hc, 32'h0001_5531);
	endtask
	task automatic testFlags();
		widthZero = 5'h02;
		modeZero = FLA_SIGN_EXT;
		widthOne = 5'h01;
		modeOne = FLA_SIGN_EXT;
		waitCycles = 4'h1;
		loadAndCheck(1'b0, 1'b1, 4'hf, 32'h0000_0001);
		widthOne = 5'h01;
		loadAndCheck(1'b1, 1'b0, 4'h0, 32'h0000_0000);
	endtask
	task automatic testForeign();
		wordValid = 1'b1;
		sendWord(16'h0000);
		`CHK({opcodeReject, busy}, 2'b10)
		sendWord({6'h01, 1'b0, 4'hc, 5'h00});
		wordValid = 1'b0;
		`CHK({opcodeReject, busy}, 2'b10)
		@(posedge clk_sys);
		#10;
		`CHK({opcodeReject, busy}, 2'b00)
	endtask
	initial
	begin
		repeat (2) @(posedge clk_sys);
		#10;
		reset = 1'b0;
		`CHK({wordReady, busy}, 2'b10)
		testZeroExtend();
		testSignWide();
		testFlags();
		testForeign();
		reportAndStop();
	end
endmodule
`default_nettype wire
